// ===== logic/fwbp_flash_seq.sv
module fwbp_flash_seq
   import fwbp_pkg::*;
#(
   parameter logic [15:0] MFR_ID = 16'h00a5, // Arbitrary value
   parameter logic [15:0] DEV_ID = 16'h5a3c // Arbitrary value
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Protect / acceleration pin levels
   input wire logic protect_low_i,
   input wire logic elevated_voltage_level_i,
   // Array interface
   input wire logic [15:0] array_rdata_i,
   output logic [21:0] array_addr_o,
   output logic prog_we_o,
   output logic [21:0] prog_addr_o,
   output logic [15:0] prog_data_o
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   localparam int PF_BOUND = int'(PFAULT_CYC) + 1;

   fwbp_regs_t s, n;
   logic accept;
   logic cw;
   logic [21:0] ca;
   logic [15:0] cd;
   logic [7:0] csec;
   logic eng_start;
   logic eng_busy;
   logic eng_step;
   logic eng_done;
   logic [4:0] eng_idx;
   logic stat_here;
   logic [15:0] stat_word;
   logic [15:0] asel_word;
   logic [15:0] rd_word;

   // ---------------------------------------------------------------
   // Program engine
   // ---------------------------------------------------------------
   fwbp_prog_engine u_eng (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .start_i(eng_start),
      .run_i(s.st == S_BUSY),
      .fast_i(elevated_voltage_level_i),
      .busy_o(eng_busy),
      .step_o(eng_step),
      .done_o(eng_done),
      .idx_o(eng_idx)
   );

   // ---------------------------------------------------------------
   // Command cycle and read decode
   // ---------------------------------------------------------------
   // A command cycle is the data phase of a write to the data register
   assign accept = hsel_i && hready_i && htrans_i[1];
   assign cw = s.wpend && (s.boff == OFF_WDATA);
   assign ca = s.addr;
   assign cd = hwdata_i[15:0];
   assign csec = fwbp_sec_of(ca);

   // Status shows only in the bank of the running or failed operation
   assign stat_here = (s.st == S_BUSY || s.st == S_ABORT || s.st == S_PFLT)
                      && (s.addr[21:19] == s.obank);

   // Polling word: complement while busy or aborted, abort flag, timeout low
   always_comb begin
      stat_word = 16'h0000;
      stat_word[ST_POLL] = ~s.ldat[7];
      stat_word[ST_TOG] = s.tog;
      stat_word[ST_TMO] = 1'b0;
      stat_word[ST_ETOG] = 1'b0;
      stat_word[ST_ABORT] = (s.st == S_ABORT);
   end

   // Only the low byte selects a code; upper bits pick the sector
   always_comb begin
      case (s.addr[7:0])
         AS_MFR: asel_word = MFR_ID;
         AS_DEV: asel_word = DEV_ID;
         AS_PROT: asel_word = {15'd0, ~s.slock[csec] | protect_low_i};
         default: asel_word = 16'h0000;
      endcase
   end

   // Read source: status, autoselect for the chosen bank, else array
   always_comb begin
      if (stat_here) begin
         rd_word = stat_word;
      end else if (s.st == S_ASEL && s.addr[21:19] == s.abank) begin
         rd_word = asel_word;
      end else begin
         rd_word = array_rdata_i;
      end
   end

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      n = s;
      eng_start = 1'b0;
      n.pwe = 1'b0;
      n.wpend = 1'b0;

      // Address phase capture; reads cost one wait state so that a read
      // right after a command write sees the updated state
      if (accept) begin
         n.boff = haddr_i[31:8] == 24'd0 ? haddr_i[7:0] : 8'hff;
         n.wpend = hwrite_i;
         n.rpend = ~hwrite_i;
      end

      // Read data phase; reading status advances the toggle bit
      if (s.rpend) begin
         n.rpend = 1'b0;
         case (s.boff)
            OFF_ADDR: n.hrd = {10'd0, s.addr};
            OFF_RDATA: begin
               n.hrd = {16'd0, rd_word};
               if (stat_here) begin
                  n.tog = ~s.tog;
               end
            end
            OFF_STAT: n.hrd = {24'd0, s.st, s.st == S_ASEL, s.st == S_SUSP,
                               s.st == S_ABORT, eng_busy};
            default: n.hrd = 32'd0;
         endcase
      end

      // Address register write
      if (s.wpend && s.boff == OFF_ADDR) begin
         n.addr = hwdata_i[21:0];
      end

      // Protection-fault polling window
      if (s.st == S_PFLT) begin
         if (s.pft <= 8'd1) begin
            n.st = S_IDLE;
         end else begin
            n.pft = s.pft - 8'd1;
         end
      end

      // Programming finished
      if (s.st == S_BUSY && eng_done) begin
         n.st = S_IDLE;
      end

      // Emit buffered words; unloaded slots are skipped
      if (eng_step) begin
         n.pwe = s.vld[eng_idx];
         n.padr = {s.page, eng_idx};
         n.pdat = s.buff[eng_idx];
      end

      // Command sequencer
      if (cw) begin
         case (s.st)
            S_IDLE, S_ASEL: begin
               if (cd == CMD_RESET) begin
                  n.st = S_IDLE;
               end else if (ca[10:0] == UNL1_ADR[10:0] && cd == CMD_UNL1) begin
                  n.st = S_UNL1;
               end
            end
            S_UNL1: begin
               n.st = (ca[10:0] == UNL2_ADR[10:0] && cd == CMD_UNL2) ? S_UNL2 : S_IDLE;
            end
            S_UNL2: begin
               n.st = S_IDLE;
               case (cd)
                  CMD_BUF_LOAD: begin
                     n.sec = csec;
                     n.obank = ca[21:19];
                     if (!s.slock[csec] || protect_low_i) begin
                        n.st = S_PFLT;
                        n.pft = PFAULT_CYC;
                        n.ldat = 16'h0000;
                     end else begin
                        n.st = S_WCNT;
                     end
                  end
                  CMD_ASEL: begin
                     n.st = S_ASEL;
                     n.abank = ca[21:19];
                  end
                  CMD_LOCK_SET: n.slock[csec] = 1'b0;
                  CMD_LOCK_CLR: n.slock[csec] = 1'b1;
                  CMD_LOCKREG: n.slock = '1;
                  default: n.st = S_IDLE;
               endcase
            end
            S_WCNT: begin
               if (cd > BUF_MAX || csec != s.sec) begin
                  n.st = S_ABORT;
               end else begin
                  n.cnt = cd[4:0];
                  n.first = 1'b1;
                  n.vld = '0;
                  n.st = S_WLOAD;
               end
            end
            S_WLOAD: begin
               if (csec != s.sec) begin
                  n.st = S_ABORT;
               end else if (!s.first && ca[21:5] != s.page) begin
                  n.st = S_ABORT;
               end else begin
                  n.page = ca[21:5];
                  n.first = 1'b0;
                  n.buff[ca[4:0]] = cd;
                  n.vld[ca[4:0]] = 1'b1;
                  n.ldat = cd;
                  if (s.cnt == 5'd0) begin
                     n.st = S_WCONF;
                  end else begin
                     n.cnt = s.cnt - 5'd1;
                  end
               end
            end
            S_WCONF: begin
               if (cd == CMD_CONFIRM && csec == s.sec) begin
                  eng_start = 1'b1;
                  n.st = S_BUSY;
               end else begin
                  n.st = S_ABORT;
               end
            end
            S_BUSY: begin
               // Only suspend is heard while programming
               if (cd == CMD_SUSP) begin
                  n.st = S_SUSP;
               end
            end
            S_SUSP: begin
               if (cd == CMD_RESUME) begin
                  n.st = S_BUSY;
               end
            end
            S_ABORT: begin
               if (cd == CMD_RESET) begin
                  n.st = S_IDLE;
               end
            end
            default: n.st = s.st;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State register; lock bits come up unprotected
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s <= '0;
         s.slock <= '1;
      end else begin
         s <= n;
      end
   end

   // Outputs
   assign hrdata_o = s.hrd;
   assign hreadyout_o = ~s.rpend;
   assign hresp_o = 1'b0;
   assign array_addr_o = s.addr;
   assign prog_we_o = s.pwe;
   assign prog_addr_o = s.padr;
   assign prog_data_o = s.pdat;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   count_abort_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (s.st == S_WCNT && cw && cd > BUF_MAX) |=> s.st == S_ABORT)
      else $error("oversize count did not abort");

   page_abort_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (s.st == S_WLOAD && cw && !s.first && ca[21:5] != s.page) |=> s.st == S_ABORT)
      else $error("load outside page did not abort");

   sector_abort_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (s.st == S_WLOAD && cw && csec != s.sec) |=> s.st == S_ABORT && s.vld == $past(s.vld))
      else $error("load to other sector did not abort");

   confirm_abort_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (s.st == S_WCONF && cw && cd != CMD_CONFIRM) |=> s.st == S_ABORT && !eng_busy)
      else $error("wrong confirm did not abort");

   abort_hold_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (s.st == S_ABORT && !(cw && cd == CMD_RESET)) |=> s.st == S_ABORT)
      else $error("abort left without reset command");

   abort_status_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (s.rpend && s.boff == OFF_RDATA && s.st == S_ABORT && stat_here)
      |=> s.hrd[ST_ABORT] && !s.hrd[ST_TMO] && s.hrd[ST_POLL] != s.ldat[7]
          && s.tog != $past(s.tog))
      else $error("abort status word wrong");

   lock_pin_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (s.st == S_UNL2 && cw && cd == CMD_BUF_LOAD && protect_low_i) |=> s.st == S_PFLT)
      else $error("protect pin low did not lock sector");

   fault_return_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      $rose(s.st == S_PFLT) |-> (s.st == S_PFLT) [*2] ##[1:PF_BOUND] s.st == S_IDLE)
      else $error("protection fault did not return to read");

   lock_reset_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      $rose(resetn_i) |-> &s.slock)
      else $error("lock bits not unprotected after reset");

   counter_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (s.st == S_WLOAD && cw && s.cnt == 5'd0 && csec == s.sec && (s.first || ca[21:5] == s.page))
      |=> s.st == S_WCONF ##1 s.vld[$past(ca[4:0], 2)])
      else $error("counter underflow did not expect confirm");

   done_read_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (s.st == S_BUSY && eng_done) |=> s.st == S_IDLE)
      else $error("did not return to read after programming");

endmodule // fwbp_flash_seq

// ===== logic/fwbp_pkg.sv
package fwbp_pkg;

   // ---------------------------------------------------------------
   // Register map (byte offsets, word aligned)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_ADDR = 8'h00;
   localparam logic [7:0] OFF_WDATA = 8'h04;
   localparam logic [7:0] OFF_RDATA = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0c;

   // ---------------------------------------------------------------
   // Command cycles
   // ---------------------------------------------------------------
   localparam logic [21:0] UNL1_ADR = 22'h000555;
   localparam logic [21:0] UNL2_ADR = 22'h0002aa;
   localparam logic [15:0] CMD_UNL1 = 16'h00aa;
   localparam logic [15:0] CMD_UNL2 = 16'h0055;
   localparam logic [15:0] CMD_BUF_LOAD = 16'h0025;
   localparam logic [15:0] CMD_CONFIRM = 16'h0029;
   localparam logic [15:0] CMD_RESET = 16'h00f0;
   localparam logic [15:0] CMD_ASEL = 16'h0090;
   localparam logic [15:0] CMD_LOCK_SET = 16'h0048;
   localparam logic [15:0] CMD_LOCK_CLR = 16'h0049;
   localparam logic [15:0] CMD_LOCKREG = 16'h0040;
   localparam logic [15:0] CMD_SUSP = 16'h00b0;
   localparam logic [15:0] CMD_RESUME = 16'h0030;

   // ---------------------------------------------------------------
   // Sizes, status bit positions, autoselect offsets
   // ---------------------------------------------------------------
   localparam int NSECT = 131;
   localparam logic [15:0] BUF_MAX = 16'h001f;
   localparam logic [4:0] LAST_IDX = 5'h1f;
   localparam int ST_POLL = 7;
   localparam int ST_TOG = 6;
   localparam int ST_TMO = 5;
   localparam int ST_ETOG = 2;
   localparam int ST_ABORT = 1;
   localparam logic [7:0] AS_MFR = 8'h00;
   localparam logic [7:0] AS_DEV = 8'h01;
   localparam logic [7:0] AS_PROT = 8'h02;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int PROG_STEP_NS = 250;
   localparam int FAST_STEP_NS = 125;
   localparam int PFAULT_NS = 100;
   localparam logic [7:0] PROG_STEP_CYC = 8'((PROG_STEP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] FAST_STEP_CYC = 8'((FAST_STEP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] PFAULT_CYC = 8'((PFAULT_NS * CLK_MHZ + 999) / 1000);

   typedef enum logic [3:0] {
      S_IDLE = 4'h0, S_UNL1 = 4'h1, S_UNL2 = 4'h3, S_WCNT = 4'h2,
      S_WLOAD = 4'h6, S_WCONF = 4'h7, S_BUSY = 4'h5, S_SUSP = 4'h4,
      S_ABORT = 4'hc, S_PFLT = 4'hd, S_ASEL = 4'hb
   } fwbp_state_t;

   typedef struct packed {
      logic busy;
      logic [4:0] idx;
      logic [7:0] tmr;
   } fwbp_eng_t;

   typedef struct packed {
      fwbp_state_t st;
      logic [21:0] addr;
      logic [31:0] hrd;
      logic rpend;
      logic wpend;
      logic [7:0] boff;
      logic [7:0] sec;
      logic [2:0] obank;
      logic [2:0] abank;
      logic [16:0] page;
      logic [4:0] cnt;
      logic first;
      logic [31:0][15:0] buff;
      logic [31:0] vld;
      logic [15:0] ldat;
      logic tog;
      logic [NSECT-1:0] slock;
      logic [7:0] pft;
      logic pwe;
      logic [21:0] padr;
      logic [15:0] pdat;
   } fwbp_regs_t;

   // Uniform 32 kword sectors, top one split into four 8 kword sectors
   function automatic logic [7:0] fwbp_sec_of(input logic [21:0] a);
      if (a[21:15] == 7'h7f) begin
         return 8'd127 + {6'd0, a[14:13]};
      end
      return {1'b0, a[21:15]};
   endfunction

endpackage

// ===== logic/fwbp_prog_engine.sv
module fwbp_prog_engine
   import fwbp_pkg::*;
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Control
   input wire logic start_i,
   input wire logic run_i,
   input wire logic fast_i,
   // Progress
   output logic busy_o,
   output logic step_o,
   output logic done_o,
   output logic [4:0] idx_o
);

   fwbp_eng_t s, n;

   // ---------------------------------------------------------------
   // Walk all buffer slots, one per word-program time
   // ---------------------------------------------------------------
   // Speed is picked per word, so raising the pin mid-run takes effect
   always_comb begin
      n = s;
      step_o = 1'b0;
      done_o = 1'b0;
      if (start_i) begin
         n.busy = 1'b1;
         n.idx = '0;
         n.tmr = fast_i ? FAST_STEP_CYC : PROG_STEP_CYC;
      end else if (s.busy && run_i) begin
         if (s.tmr == 8'd1) begin
            step_o = 1'b1;
            if (s.idx == LAST_IDX) begin
               n.busy = 1'b0;
               done_o = 1'b1;
            end else begin
               n.idx = s.idx + 5'd1;
               n.tmr = fast_i ? FAST_STEP_CYC : PROG_STEP_CYC;
            end
         end else begin
            n.tmr = s.tmr - 8'd1;
         end
      end
   end

   // State register
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign busy_o = s.busy;
   assign idx_o = s.idx;

   // Done only in the cycle that steps the last slot, before its write strobe
   eng_done_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      done_o |-> (s.idx == LAST_IDX) && step_o ##1 !s.busy)
      else $error("engine finished before last slot");

endmodule // fwbp_prog_engine

// ===== test/fwbp_array_model.sv
// ---------------------------------------------------------------
// Flash array stand-in behind the sequencer
// ---------------------------------------------------------------
module fwbp_array_model (
   // Clock
   input wire logic clock_i,
   // Array port
   input wire logic [21:0] array_addr_i,
   output logic [15:0] array_rdata_o,
   input wire logic prog_we_i,
   input wire logic [21:0] prog_addr_i,
   input wire logic [15:0] prog_data_i
);
   // Indexed by the low 12 bits only: test addresses must differ there
   logic [15:0] mem [4096];
   logic [4095:0] vld = '0;

   // Unwritten words read as an address pattern, never a stale value
   assign array_rdata_o = vld[array_addr_i[11:0]] ? mem[array_addr_i[11:0]] : (array_addr_i[15:0] ^ 16'h5a5a);

   // One word programmed per strobe
   always @(posedge clock_i) begin
      if (prog_we_i) begin
         mem[prog_addr_i[11:0]] <= prog_data_i;
         vld[prog_addr_i[11:0]] <= 1'b1;
      end
   end
endmodule // fwbp_array_model

// ===== test/test_flash_write_buffer_protection.sv
module test_flash_write_buffer_protection
   import fwbp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   localparam logic [21:0] A0 = 22'h010040;
   localparam logic [21:0] A1 = 22'h010100;
   localparam logic [21:0] A2 = 22'h010200;
   localparam logic [21:0] S2P = 22'h010002;
   localparam logic [15:0] MID = 16'h0c3d; // Arbitrary value
   localparam logic [15:0] DID = 16'h7e21; // Arbitrary value
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic plow = 1'b0;
   logic elev = 1'b0;
   logic [31:0] haddr = '0;
   logic [31:0] hwdata = '0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   logic pwe;
   logic [21:0] aadr;
   logic [21:0] padr;
   logic [15:0] ard;
   logic [15:0] pdat;
   logic [31:0] q;
   logic [31:0] q2;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   int t0;
   int tn;
   int tf;

   fwbp_flash_seq #(.MFR_ID(MID), .DEV_ID(DID)) uut (.clock_i(clock_i), .resetn_i(resetn_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .protect_low_i(plow),
      .elevated_voltage_level_i(elev), .array_rdata_i(ard), .array_addr_o(aadr), .prog_we_o(pwe),
      .prog_addr_o(padr), .prog_data_o(pdat));
   fwbp_array_model arr (.clock_i(clock_i), .array_addr_i(aadr), .array_rdata_o(ard), .prog_we_i(pwe),
      .prog_addr_i(padr), .prog_data_i(pdat));

   // Clock and cycle count
   initial forever #12.5 clock_i = ~clock_i;
   always @(posedge clock_i) cyc <= cyc + 1;

   // ---------------------------------------------------------------
   // Bus and command tasks
   // ---------------------------------------------------------------
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clock_i);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge clock_i);
      while (hready !== 1'b1) @(posedge clock_i);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge clock_i);
      while (hready !== 1'b1) @(posedge clock_i);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      xfer(1'b0, a, 32'h0, r);
   endtask
   task automatic fw(input logic [21:0] a, input logic [15:0] d);
      wr(OFF_ADDR, {10'h0, a});
      wr(OFF_WDATA, {16'h0, d});
   endtask
   task automatic rdf(input logic [21:0] a, output logic [31:0] r);
      wr(OFF_ADDR, {10'h0, a});
      rd(OFF_RDATA, r);
   endtask
   task automatic cmd(input logic [21:0] a, input logic [15:0] c);
      fw(UNL1_ADR, CMD_UNL1);
      fw(UNL2_ADR, CMD_UNL2);
      fw(a, c);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Bounded poll of the engine busy flag
   task automatic wait_idle;
      logic [31:0] r;
      for (int i = 0; i < 400; i++) begin
         rd(OFF_STAT, r);
         if (r[0] === 1'b0) break;
      end
      chk("idle", 32'h0, {31'h0, r[0]});
   endtask
   task automatic prot(input logic [15:0] e);
      cmd(22'h0, CMD_ASEL);
      rdf(S2P, q);
      chk("prot", {16'h0, e}, {16'h0, q[15:0]});
      fw(22'h0, CMD_RESET);
   endtask
   // One-word buffered operation at a
   task automatic prog(input logic [21:0] a, input logic [15:0] d);
      cmd(a, CMD_BUF_LOAD);
      fw(a, 16'h0000);
      fw(a, d);
      fw(a, CMD_CONFIRM);
      wait_idle;
   endtask
   task automatic tally_and_finish;
      if (n_fail == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Watchdog, far beyond the expected run of some 2000 cycles
   initial begin
      #2000000;
      n_fail++;
      tally_and_finish;
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clock_i);
      resetn_i <= 1'b1;
      prot(16'h0000);
      // Three loads, one repeated location; last data wins
      cmd(A0, CMD_BUF_LOAD);
      fw(A0, 16'h0002);
      fw(A0, 16'h1111);
      fw(A0 + 22'h1, 16'h2222);
      fw(A0 + 22'h1, 16'h3381);
      fw(A0 + 22'h1, CMD_CONFIRM);
      t0 = cyc;
      rd(OFF_RDATA, q);
      chk("busy_poll", 32'h0, {30'h0, q[7], q[1]});
      cmd(22'h0, CMD_ASEL);
      rd(OFF_STAT, q);
      chk("asel_in_busy", 32'h1, {30'h0, q[3], q[0]});
      // Suspend pauses the engine with the job still pending
      fw(A0 + 22'h1, CMD_SUSP);
      rd(OFF_STAT, q);
      chk("suspended", 32'h5, {29'h0, q[2], q[1], q[0]});
      fw(A0 + 22'h1, CMD_RESUME);
      wait_idle;
      tn = cyc - t0;
      rdf(A0, q);
      chk("word0", 32'h1111, {16'h0, q[15:0]});
      rdf(A0 + 22'h1, q);
      chk("word1", 32'h3381, {16'h0, q[15:0]});
      chk("hresp", 32'h0, {31'h0, hresp});
      // Elevated pin level shortens the program steps
      elev <= 1'b1;
      t0 = cyc;
      prog(A1, 16'h00ff);
      tf = cyc - t0;
      elev <= 1'b0;
      chk("accel", 32'h1, {31'h0, 1'(tf + 100 < tn)});
      // Abort causes: oversize count, other page, other sector, no confirm
      for (int k = 0; k < 4; k++) begin
         cmd(A2, CMD_BUF_LOAD);
         if (k == 0) fw(A2, 16'h0020);
         else fw(A2, k == 3 ? 16'h0000 : 16'h0001);
         if (k != 0) fw(A2, 16'h0080);
         if (k == 1) fw(A2 + 22'h20, 16'h0080);
         if (k == 2) fw(A2 + 22'h8000, 16'h0080);
         if (k == 3) fw(A2, 16'h0000);
         fw(UNL1_ADR, CMD_UNL1);
         wr(OFF_ADDR, {10'h0, A2});
         rd(OFF_STAT, q);
         chk("abort_flag", 32'h1, {31'h0, q[1]});
         rd(OFF_RDATA, q);
         rd(OFF_RDATA, q2);
         chk("abort_bits", 32'h1, {29'h0, q[5], q[2], q[1]});
         chk("abort_toggle", 32'h1, {31'h0, q[6] ^ q2[6]});
         if (k != 0) chk("abort_poll", 32'h0, {31'h0, q[7]});
         fw(A2, CMD_RESET);
         rd(OFF_STAT, q);
         chk("abort_left", 32'h0, {31'h0, q[1]});
         rdf(A2, q);
         chk("abort_array", {16'h0, A2[15:0] ^ 16'h5a5a}, q);
      end
      // Identifier codes, and array data in another bank
      cmd(22'h0, CMD_ASEL);
      rdf(22'h000000, q);
      chk("mfr", {16'h0, MID}, {16'h0, q[15:0]});
      rdf(22'h000001, q);
      chk("dev", {16'h0, DID}, {16'h0, q[15:0]});
      rdf(22'h080200, q);
      chk("bank_array", 32'h5a5a ^ 32'h0200, {16'h0, q[15:0]});
      fw(22'h0, CMD_RESET);
      // Lock bits: set, fault, hardware reset, lock register, clear
      cmd(A0, CMD_LOCK_SET);
      prot(16'h0001);
      prog(A0, 16'hbeef);
      rdf(A0, q);
      chk("locked", 32'h1111, {16'h0, q[15:0]});
      @(posedge clock_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      resetn_i <= 1'b1;
      prot(16'h0000);
      cmd(A0, CMD_LOCK_SET);
      cmd(22'h0, CMD_LOCKREG);
      prot(16'h0000);
      cmd(A0, CMD_LOCK_SET);
      cmd(A0, CMD_LOCK_CLR);
      prot(16'h0000);
      // Protect pin low blocks every sector
      plow <= 1'b1;
      prog(A0, 16'hbeef);
      plow <= 1'b0;
      rdf(A0, q);
      chk("pin_lock", 32'h1111, {16'h0, q[15:0]});
      prog(A0, 16'h0bee);
      rdf(A0, q);
      chk("pin_free", 32'h0bee, {16'h0, q[15:0]});
      tally_and_finish;
   end
endmodule // test_flash_write_buffer_protection
